// *** verification/dca_chk.sv ***
// Port assertions for the DMA channel core
`timescale 1ns/1ps
module dca_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] transfer_ack_strobe_n,
	input wire logic bus_req,
	input wire logic bus_grant,
	input wire logic [31:0] mem_addr,
	input wire logic mem_read,
	input wire logic mem_write,
	input wire logic mem_ready
);
	// ----------------------------------------------------------------
	// Bus and strobe relations
	// ----------------------------------------------------------------
	logic strobe;
	logic dual;
	assign strobe = mem_read || mem_write;
	assign dual = &transfer_ack_strobe_n;
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	a_one_ack: assert property ($onehot0(~transfer_ack_strobe_n))
		else $error("two ack strobes low");
	a_rw_excl: assert property (!(mem_read && mem_write))
		else $error("read and write together");
	a_bus_held: assert property (strobe |-> bus_req)
		else $error("strobe without bus request");
	a_grant_first: assert property ($rose(strobe) |-> $past(bus_grant))
		else $error("cycle started without grant");
	a_strobe_hold: assert property (strobe && !mem_ready |=>
		$stable(mem_addr) && $stable(mem_read) && $stable(mem_write))
		else $error("bus cycle changed before ready");
	a_dual_turn: assert property (mem_read && mem_ready && dual
		|=> mem_write)
		else $error("no write after dual read");
	a_unit_gap: assert property (strobe && mem_ready
		&& (mem_write || !dual) |=> !strobe)
		else $error("no boundary after unit");
	a_ack_cycle: assert property (!dual |-> strobe)
		else $error("ack strobe without bus cycle");
	a_ack_chan: assert property (transfer_ack_strobe_n[3:2] == 2'h3)
		else $error("ack strobe on channel 2 or 3");
	c_dual: cover property (mem_write && mem_ready && dual);
	c_single: cover property (!transfer_ack_strobe_n[0] && mem_ready);
	c_back: cover property (strobe && mem_ready ##2 strobe);
endmodule

bind dca_top dca_chk chk_u (.*);

// *** verification/dca_mem_model.sv ***
// Far side: outside bus arbiter and memory with a set stall
`timescale 1ns/1ps
module dca_mem_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [1:0] lag,
	input wire logic bus_req,
	input wire logic mem_read,
	input wire logic mem_write,
	input wire logic [31:0] mem_addr,
	output logic bus_grant,
	output logic [31:0] mem_rdata,
	output logic mem_ready
);
	// ----------------------------------------------------------------
	// Grant and ready after lag cycles
	// ----------------------------------------------------------------
	logic [1:0] gcnt;
	logic [1:0] rcnt;
	logic [31:0] noise;
	logic strobe;
	assign strobe = mem_read || mem_write;
	// Grant waits, as if another master still held the bus
	assign bus_grant = bus_req && gcnt == lag;
	assign mem_ready = strobe && rcnt == lag;
	// Idle bus moves each cycle so stale data never matches
	assign mem_rdata = mem_read ? ~mem_addr : noise;
	always_ff @(posedge aclk) begin
		if (!aresetn || !bus_req)
			gcnt <= 2'h0;
		else if (gcnt != lag)
			gcnt <= gcnt + 2'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || !strobe || mem_ready)
			rcnt <= 2'h0;
		else
			rcnt <= rcnt + 2'h1;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			noise <= 32'h1;
		else
			noise <= {noise[30:0], ~noise[31]} ^ 32'h5A5A_0001;
	end
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the DMA channel core
`timescale 1ns/1ps
module testbench
	import dca_pkg::*;
;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
	logic [3:0] s_axi_wstrb = 4'hF, transfer_request_pin_n = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, mem_ready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, bus_req, bus_grant, mem_read, mem_write;
	logic [1:0] s_axi_bresp, s_axi_rresp, mem_size, rs, lag = 2'h0;
	logic [31:0] s_axi_rdata, mem_addr, mem_wdata, mem_rdata, last_rd, rv;
	logic [3:0] transfer_ack_strobe_n;
	int err_total = 0, comparisons = 0, cyc = 0, units = 0;
	int exp_q[$], seen_q[$];
	int rj_ch[5] = '{2, 0, 1, 0, 1};
	logic [31:0] rj_v[5] = '{32'h15, 32'h5, 32'h215, 32'hC1D, 32'h15};
	logic rj_e[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
	// Only fixed order, contiguous runs or a single channel are chosen
	logic [3:0] rr_tab[6] = '{4'h0, 4'hF, 4'h1, 4'h2, 4'h4, 4'h8};

	always #12.5 aclk = ~aclk;
	dca_top dut_u (.*);
	dca_mem_model far_u (.aclk(aclk), .aresetn(aresetn), .lag(lag),
		.bus_req(bus_req), .mem_read(mem_read), .mem_write(mem_write),
		.mem_addr(mem_addr), .bus_grant(bus_grant),
		.mem_rdata(mem_rdata), .mem_ready(mem_ready));

	// ----------------------------------------------------------------
	// Checking, closing and bus tasks
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [31:0] s, e);
		comparisons++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic close_out();
		$display("mismatches %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			err_total++;
			close_out();
		end
	end
	// Source base carries the channel number in address bits 17:16
	always @(posedge aclk) begin
		if (!aresetn)
			units <= 0;
		else if (mem_ready && !transfer_ack_strobe_n[0])
			units <= units + 1;
		if (aresetn && mem_ready && &transfer_ack_strobe_n) begin
			if (mem_read) begin
				seen_q.push_back(int'(mem_addr[17:16]));
				chk("unit_size", 32'(mem_size), 32'h2);
				last_rd <= mem_addr;
			end
			if (mem_write) begin
				chk("hold_data", mem_wdata, ~last_rd);
				chk("dst_base", 32'(mem_addr[31:28]), 32'h2);
			end
		end
	end
	task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [31:0] a, output logic [31:0] d,
		output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic do_reset();
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
	endtask

	// ----------------------------------------------------------------
	// Expected service order and one arbitration round
	// ----------------------------------------------------------------
	function automatic void build_exp(logic [3:0] rr, int c[4]);
		int pr[4];
		int w;
		exp_q.delete();
		for (int i = 0; i < 4; i++)
			pr[i] = i;
		while (c[0] + c[1] + c[2] + c[3] > 0) begin
			for (int i = 3; i >= 0; i--)
				if (c[pr[i]] > 0)
					w = pr[i];
			exp_q.push_back(w);
			c[w]--;
			if (rr == 4'hF)
				for (int i = 0; i < 4; i++)
					pr[i] = (w + 1 + i) % 4;
		end
	endfunction
	task automatic round(input logic [3:0] rr, input logic bm, input int fc);
		int c[4];
		logic [3:0] mask;
		logic [31:0] b;
		lag <= 2'($urandom_range(0, 2));
		do_reset();
		for (int k = 0; k < 4; k++) begin
			c[k] = fc > 0 ? fc : $urandom_range(0, 3);
			mask[k] = c[k] > 0;
			b = 32'h10 + 32'h10 * k;
			wr(b + 32'h4, 32'h1000_0000 + (32'(k) << 16), rs);
			wr(b + 32'h8, 32'h2000_0000 + (32'(k) << 16), rs);
			wr(b + 32'hC, 32'(c[k]), rs);
			// Random memory kinds, 32-bit units, auto request
			wr(b, {20'h0, 2'($urandom), 2'($urandom), 6'h10, bm, mask[k]},
				rs);
		end
		build_exp(rr, c);
		seen_q.delete();
		wr(OFF_OPER, {24'h0, rr, 4'h1}, rs);
		rd(OFF_STAT, rv, rs);
		for (int i = 0; i < 300 && rv[3:0] !== mask; i++)
			rd(OFF_STAT, rv, rs);
		chk("done", 32'(rv[3:0]), 32'(mask));
		chk("units", seen_q.size(), exp_q.size());
		foreach (exp_q[i])
			chk("order", seen_q[i], exp_q[i]);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h2C02));
		do_reset();
		rd(OFF_OPER, rv, rs);
		chk("oper_reset", rv, 32'h0);
		rd(32'h100, rv, rs);
		chk("unmapped_rd", {rv[31:2], rs}, {30'h0, RESP_SLVERR});
		wr(32'h100, 32'h1, rs);
		chk("unmapped_wr", 32'(rs), 32'(RESP_SLVERR));
		for (int k = 0; k < 5; k++) begin
			wr(32'h10 + 32'h10 * rj_ch[k], rj_v[k], rs);
			rd(OFF_OPER, rv, rs);
			chk("err_flag", 32'(rv[1]), 32'(rj_e[k]));
			rd(32'h10 + 32'h10 * rj_ch[k], rv, rs);
			chk("ctl_back", rv, rj_v[k] & ~32'(rj_e[k]));
			wr(OFF_OPER, 32'h0, rs);
		end
		round(4'hF, 1'b0, 2);
		round(4'h0, 1'b1, 2);
		repeat (6)
			round(rr_tab[$urandom_range(0, 5)], 1'($urandom), 0);
		// Single address burst on channel 0, request dropped early
		do_reset();
		wr(32'h14, 32'h3000_0000, rs);
		wr(32'h1C, 32'h8, rs);
		wr(32'h10, 32'h57, rs);
		wr(OFF_OPER, 32'h1, rs);
		transfer_request_pin_n <= 4'hE;
		while (units == 0)
			@(posedge aclk);
		transfer_request_pin_n <= 4'hF;
		while (bus_req)
			@(posedge aclk);
		chk("early_release", 32'(units < 8), 32'h1);
		rd(32'h1C, rv, rs);
		chk("remaining", rv, 32'(8 - units));
		close_out();
	end
endmodule

// *** verilog/dca_arbiter.sv ***
// Channel priority arbiter, fixed or round-robin over a channel run
`timescale 1ns/1ps
module dca_arbiter
	import dca_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [3:0] req,
	input wire logic [3:0] rr_sel,
	input wire logic unit_done,
	input wire logic [1:0] done_ch,
	output logic grant_valid,
	output logic [1:0] grant_ch
);
	logic [1:0] top_ptr;
	logic [1:0] lo;
	logic [1:0] hi;
	logic [1:0] base;
	logic [2:0] len;
	logic [2:0] key;
	logic [2:0] k;
	logic [2:0] best;

	always_comb begin
		lo = 2'h0;
		len = 3'h0;
		key = 3'h0;
		k = 3'h0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (rr_sel[i]) begin
				lo = 2'(i);
			end
		end
		for (int i = 0; i < NCH; i++) begin
			len = len + 3'(rr_sel[i]);
		end
		hi = 2'(3'(lo) + len - 3'h1);
		base = rr_sel[top_ptr] ? top_ptr : lo;
		grant_valid = |req;
		grant_ch = 2'h0;
		best = 3'h7;
		for (int i = 0; i < NCH; i++) begin
			// Channels outside the run keep their fixed slot
			key = 3'(i);
			if (len > 3'h1 && rr_sel[i]) begin
				k = 3'(i) + len - 3'(base);
				if (k >= len) begin
					k = k - len;
				end
				key = 3'(lo) + k;
			end
			if (req[i] && key < best) begin
				best = key;
				grant_ch = 2'(i);
			end
		end
	end

	// Served channel drops to the bottom of the run
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			top_ptr <= 2'h0;
		end else if (unit_done && len > 3'h1 && rr_sel[done_ch]) begin
			top_ptr <= (done_ch == hi) ? lo : done_ch + 2'h1;
		end
	end
endmodule

// *** verilog/dca_axil.sv ***
// AXI4-Lite slave front end feeding the register file
`timescale 1ns/1ps
module dca_axil
	import dca_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	dca_reg_if.slv rg
);
	logic aw_got;
	logic w_got;
	logic next_aw_got;
	logic next_w_got;
	logic next_bvalid;
	logic next_rvalid;
	logic ar_take;

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	assign rg.wr = aw_got & w_got & ~s_axi_bvalid;
	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign rg.rd = ar_take;
	assign rg.raddr = s_axi_araddr;

	always_comb begin
		next_aw_got = (aw_got | (s_axi_awvalid & s_axi_awready)) & ~rg.wr;
		next_w_got = (w_got | (s_axi_wvalid & s_axi_wready)) & ~rg.wr;
		next_bvalid = rg.wr | (s_axi_bvalid & ~s_axi_bready);
		next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			rg.waddr <= 32'h0000_0000;
			rg.wdata <= 32'h0000_0000;
			rg.wstrb <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				rg.waddr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				rg.wdata <= s_axi_wdata;
				rg.wstrb <= s_axi_wstrb;
			end
			if (rg.wr) begin
				s_axi_bresp <= rg.wok ? RESP_OKAY : RESP_SLVERR;
			end
			aw_got <= next_aw_got;
			w_got <= next_w_got;
			s_axi_bvalid <= next_bvalid;
			s_axi_awready <= ~next_aw_got & ~next_bvalid;
			s_axi_wready <= ~next_w_got & ~next_bvalid;
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			if (ar_take) begin
				s_axi_rdata <= rg.rdata;
				s_axi_rresp <= rg.rok ? RESP_OKAY : RESP_SLVERR;
			end
			s_axi_rvalid <= next_rvalid;
			s_axi_arready <= ~next_rvalid;
		end
	end
endmodule

// *** verilog/dca_pkg.sv ***
// Constants and types shared by the DMA channel arbiter design
package dca_pkg;
	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int NCH = 4;
	localparam logic [31:0] OFF_OPER = 32'h0000_0000;
	localparam logic [31:0] OFF_STAT = 32'h0000_0004;
	localparam logic [31:0] OFF_CH_FIRST = 32'h0000_0010;
	localparam logic [31:0] OFF_CH_LAST = 32'h0000_004C;
	localparam logic [1:0] FLD_CTRL = 2'h0;
	localparam logic [1:0] FLD_SRC = 2'h1;
	localparam logic [1:0] FLD_DST = 2'h2;
	localparam logic [1:0] FLD_CNT = 2'h3;
	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int OP_ENABLE = 0;
	localparam int OP_ERROR = 1;
	localparam int OP_RR_LSB = 4;
	localparam int CTL_EN = 0;
	localparam int CTL_BURST = 1;
	localparam int CTL_SINGLE = 2;
	localparam int CTL_DIR = 3;
	localparam int CTL_EXTREQ = 4;
	localparam int CTL_SIZE_LSB = 5;
	localparam int CTL_SRCK_LSB = 8;
	localparam int CTL_DSTK_LSB = 10;
	localparam int CTL_W = 12;
	localparam int ST_BUS_BIT = 8;
	localparam int ST_CH_LSB = 12;
	// Channels allowed to run single address transfers
	localparam logic [3:0] SINGLE_OK_CH = 4'h3;
	// ----------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [CTL_W-1:0] CTL_RESET = 12'h000;
	localparam logic [3:0] RR_RESET = 4'h0;
	localparam logic [1:0] KIND_EXT_MEM = 2'h0;
	localparam logic [1:0] KIND_MAPPED = 2'h1;
	localparam logic [1:0] KIND_ONCHIP_MEM = 2'h2;
	localparam logic [1:0] KIND_ONCHIP_PER = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ACQ = 3'b001,
		ST_READ = 3'b010,
		ST_WRITE = 3'b011,
		ST_SINGLE = 3'b100,
		ST_NEXT = 3'b101
	} dca_state_e;
endpackage

// *** verilog/dca_reg_if.sv ***
// Register access strobes between the bus slave and the register file
`timescale 1ns/1ps
interface dca_reg_if;
	logic wr;
	logic [31:0] waddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic wok;
	logic rd;
	logic [31:0] raddr;
	logic [31:0] rdata;
	logic rok;
	modport slv(output wr, waddr, wdata, wstrb, rd, raddr,
		input wok, rdata, rok);
	modport regs(input wr, waddr, wdata, wstrb, rd, raddr,
		output wok, rdata, rok);
endinterface

// *** verilog/dca_top.sv ***
// Four-channel DMA core: registers, arbitration and transfer sequencing
//
// Summary of operation
// - Simultaneous requests: grant exactly one channel
// - All round-robin selects zero means fixed
// - Reset order channel 0 down to 3
// - Round-robin: served channel drops to lowest
// - Rotation keeps the cyclic channel order
// - One selected channel behaves as fixed
// - Late requests wait for next unit boundary
// - Single address: strobe plus address, one cycle
// - Single address: strobed device, external pin only
// - Reject strobed device with on-chip parties
// - Dual address: read to holding, then write
// - Dual address accepts any memory kinds
// - Per-channel bit selects cycle steal/burst
// - Cycle steal releases bus after each unit unless a burst channel waits
// - Cycle steal allowed for every combination
// - Burst keeps bus until end condition
// - Burst releases bus once level request drops
// - Higher channel preempts burst, bus kept
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module dca_top
	import dca_pkg::*;
#(
	parameter int CNT_W = 24
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] transfer_request_pin_n,
	output logic [3:0] transfer_ack_strobe_n,
	output logic bus_req,
	input wire logic bus_grant,
	output logic [31:0] mem_addr,
	output logic [1:0] mem_size,
	output logic mem_read,
	output logic mem_write,
	output logic [31:0] mem_wdata,
	input wire logic [31:0] mem_rdata,
	input wire logic mem_ready
);
	dca_reg_if rg();

	logic [CTL_W-1:0] ctrl [NCH];
	logic [31:0] src [NCH];
	logic [31:0] dst [NCH];
	logic [CNT_W-1:0] cnt [NCH];
	logic op_enable;
	logic op_error;
	logic [3:0] rr_sel;
	logic [3:0] done;
	logic [3:0] req_meta;
	logic [3:0] req_sync;
	logic [3:0] pending;
	logic [3:0] burst;
	logic [3:0] ch_hit;
	logic [3:0] done_set;
	logic [1:0] cur;
	logic [1:0] field;
	logic [31:0] hold;
	logic [31:0] step;
	logic [31:0] ctrl_new;
	logic fin;
	logic reject;
	logic grant_valid;
	logic [1:0] grant_ch;
	dca_state_e state;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic mapped(input logic [31:0] a);
		return a == OFF_OPER || a == OFF_STAT ||
			(a >= OFF_CH_FIRST && a <= OFF_CH_LAST && a[1:0] == 2'h0);
	endfunction

	function automatic logic [1:0] ch_of(input logic [31:0] a);
		return 2'(a[5:4] - 2'h1);
	endfunction

	// ----------------------------------------------------------------
	// Bus slave and arbiter
	// ----------------------------------------------------------------
	dca_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rg(rg.slv)
	);

	dca_arbiter u_arb (
		.aclk(aclk),
		.aresetn(aresetn),
		.req(pending),
		.rr_sel(rr_sel),
		.unit_done(fin),
		.done_ch(cur),
		.grant_valid(grant_valid),
		.grant_ch(grant_ch)
	);

	// ----------------------------------------------------------------
	// Request pins and channel readiness
	// ----------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			req_meta <= 4'h0;
			req_sync <= 4'h0;
		end else begin
			req_meta <= ~transfer_request_pin_n;
			req_sync <= req_meta;
		end
	end

	// Level request dropping removes the channel from contention
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			burst[i] = ctrl[i][CTL_BURST];
			pending[i] = op_enable & ctrl[i][CTL_EN] &
				(cnt[i] != '0) &
				(~ctrl[i][CTL_EXTREQ] | req_sync[i]);
		end
	end

	// ----------------------------------------------------------------
	// Register writes
	// ----------------------------------------------------------------
	assign field = rg.waddr[3:2];
	assign rg.wok = mapped(rg.waddr);
	assign ctrl_new = merge(32'(ctrl[ch_of(rg.waddr)]), rg.wdata,
		rg.wstrb);
	// Memory side of a single address transfer must be external
	assign reject = ctrl_new[CTL_EN] && ctrl_new[CTL_SINGLE] &&
		(!ctrl_new[CTL_EXTREQ] ||
		!SINGLE_OK_CH[ch_of(rg.waddr)] ||
		(ctrl_new[CTL_DIR] ? ctrl_new[CTL_DSTK_LSB+1] :
		ctrl_new[CTL_SRCK_LSB+1]));

	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			ch_hit[i] = rg.wr && rg.wok && rg.waddr >= OFF_CH_FIRST &&
				ch_of(rg.waddr) == 2'(i);
			done_set[i] = fin && cur == 2'(i) &&
				cnt[i] == CNT_W'(1);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_enable <= 1'b0;
			op_error <= 1'b0;
			rr_sel <= RR_RESET;
		end else begin
			if (rg.wr && rg.waddr == OFF_OPER && rg.wstrb[0]) begin
				op_enable <= rg.wdata[OP_ENABLE];
				op_error <= rg.wdata[OP_ERROR];
				rr_sel <= rg.wdata[OP_RR_LSB +: 4];
			end
			// Rejection wins over a clear in the same cycle
			if (|ch_hit && field == FLD_CTRL && reject) begin
				op_error <= 1'b1;
			end
		end
	end

	generate
		for (genvar g = 0; g < NCH; g++) begin : g_ch
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					ctrl[g] <= CTL_RESET;
				end else if (ch_hit[g] && field == FLD_CTRL) begin
					ctrl[g] <= ctrl_new[CTL_W-1:0];
					if (reject) begin
						ctrl[g][CTL_EN] <= 1'b0;
					end
				end else if (done_set[g]) begin
					ctrl[g][CTL_EN] <= 1'b0;
				end
			end

			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					src[g] <= 32'h0000_0000;
					dst[g] <= 32'h0000_0000;
					cnt[g] <= '0;
				end else if (ch_hit[g]) begin
					if (field == FLD_SRC) begin
						src[g] <= merge(src[g], rg.wdata, rg.wstrb);
					end
					if (field == FLD_DST) begin
						dst[g] <= merge(dst[g], rg.wdata, rg.wstrb);
					end
					if (field == FLD_CNT) begin
						cnt[g] <= CNT_W'(merge(32'(cnt[g]), rg.wdata,
							rg.wstrb));
					end
				end else if (fin && cur == 2'(g)) begin
					if (!ctrl[g][CTL_SINGLE] || !ctrl[g][CTL_DIR]) begin
						src[g] <= src[g] + step;
					end
					if (!ctrl[g][CTL_SINGLE] || ctrl[g][CTL_DIR]) begin
						dst[g] <= dst[g] + step;
					end
					cnt[g] <= cnt[g] - CNT_W'(1);
				end
			end
		end
	endgenerate

	// Done flags: write one to clear, a new completion wins
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done <= 4'h0;
		end else if (rg.wr && rg.waddr == OFF_STAT && rg.wstrb[0]) begin
			done <= (done & ~rg.wdata[3:0]) | done_set;
		end else begin
			done <= done | done_set;
		end
	end

	// ----------------------------------------------------------------
	// Register reads
	// ----------------------------------------------------------------
	assign rg.rok = mapped(rg.raddr);

	always_comb begin
		rg.rdata = 32'h0000_0000;
		if (rg.raddr == OFF_OPER) begin
			rg.rdata[OP_ENABLE] = op_enable;
			rg.rdata[OP_ERROR] = op_error;
			rg.rdata[OP_RR_LSB +: 4] = rr_sel;
		end else if (rg.raddr == OFF_STAT) begin
			rg.rdata[3:0] = done;
			rg.rdata[ST_BUS_BIT] = bus_req;
			rg.rdata[ST_CH_LSB +: 2] = cur;
		end else if (rg.rok) begin
			unique case (rg.raddr[3:2])
				FLD_CTRL: rg.rdata = 32'(ctrl[ch_of(rg.raddr)]);
				FLD_SRC: rg.rdata = src[ch_of(rg.raddr)];
				FLD_DST: rg.rdata = dst[ch_of(rg.raddr)];
				FLD_CNT: rg.rdata = 32'(cnt[ch_of(rg.raddr)]);
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Transfer sequencer
	// ----------------------------------------------------------------
	assign fin = mem_ready && (state == ST_WRITE || state == ST_SINGLE);
	assign step = 32'h0000_0001 << ctrl[cur][CTL_SIZE_LSB +: 2];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			cur <= 2'h0;
			bus_req <= 1'b0;
			mem_addr <= 32'h0000_0000;
			mem_size <= 2'h0;
			mem_read <= 1'b0;
			mem_write <= 1'b0;
			mem_wdata <= 32'h0000_0000;
			hold <= 32'h0000_0000;
			transfer_ack_strobe_n <= 4'hF;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (grant_valid) begin
						cur <= grant_ch;
						bus_req <= 1'b1;
						state <= ST_ACQ;
					end
				end
				ST_ACQ: begin
					if (bus_grant) begin
						mem_size <= ctrl[cur][CTL_SIZE_LSB +: 2];
						if (ctrl[cur][CTL_SINGLE]) begin
							// Memory side addressed, device strobed
							mem_addr <= ctrl[cur][CTL_DIR] ?
								dst[cur] : src[cur];
							mem_read <= ~ctrl[cur][CTL_DIR];
							mem_write <= ctrl[cur][CTL_DIR];
							transfer_ack_strobe_n[cur] <= 1'b0;
							state <= ST_SINGLE;
						end else begin
							mem_addr <= src[cur];
							mem_read <= 1'b1;
							state <= ST_READ;
						end
					end
				end
				ST_READ: begin
					if (mem_ready) begin
						hold <= mem_rdata;
						mem_read <= 1'b0;
						mem_addr <= dst[cur];
						mem_write <= 1'b1;
						state <= ST_WRITE;
					end
				end
				ST_WRITE: begin
					if (mem_ready) begin
						mem_write <= 1'b0;
						state <= ST_NEXT;
					end
				end
				ST_SINGLE: begin
					if (mem_ready) begin
						mem_read <= 1'b0;
						mem_write <= 1'b0;
						transfer_ack_strobe_n <= 4'hF;
						state <= ST_NEXT;
					end
				end
				ST_NEXT: begin
					// Unit boundary: bus stays while any burst waits
					if (grant_valid && |(pending & burst)) begin
						cur <= grant_ch;
						state <= ST_ACQ;
					end else begin
						bus_req <= 1'b0;
						state <= ST_IDLE;
					end
				end
				default: state <= ST_IDLE;
			endcase
			if (state == ST_READ && mem_ready) begin
				mem_wdata <= mem_rdata;
			end else begin
				mem_wdata <= hold;
			end
		end
	end
endmodule
